// [shared/lpw_pkg.sv]
// Shared constants, register map and types of the low power wake control
package lpw_pkg;

  // Clock and timing
  localparam int CLK_MHZ = 20;
  localparam int CORE_PREP_DELAY_NS = 200;
  localparam int CORE_PREP_RAW = (CORE_PREP_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int CORE_PREP_CYCLES = (CORE_PREP_RAW < 1) ? 1 : CORE_PREP_RAW;
  localparam int OST_CYCLES_DEFAULT = 1024;
  localparam int WDT_POSTSCALE_DEFAULT = 128;
  localparam int WDT_PERIOD_DEFAULT = 256;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] IRQ_EN_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] WDT_COUNT_OFFSET = 8'h0c;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OSC_LOW_POWER_XTAL,
    OSC_STANDARD_XTAL,
    OSC_HIGH_SPEED_XTAL,
    OSC_HIGH_SPEED_XTAL_WITH_PLL,
    OSC_EXTERNAL_RC,
    OSC_EXTERNAL_CLOCK,
    OSC_INTERNAL,
    OSC_INTERNAL_IO
  } lpw_osc_mode_t;

  typedef enum logic [1:0] {
    PM_SLEEP,
    PM_PRIMARY_CLOCK_IDLE,
    PM_SECONDARY_IDLE,
    PM_RC_IDLE
  } lpw_pm_mode_t;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_ASLEEP,
    ST_OSC_START,
    ST_CORE_PREP,
    ST_RESUME
  } lpw_state_t;

  typedef enum logic [2:0] {
    CAUSE_NONE,
    CAUSE_IRQ,
    CAUSE_WDT_WAKE,
    CAUSE_WDT_RESET,
    CAUSE_RESET
  } lpw_cause_t;

  // Control register, bits [8:0] of the word at CTRL_OFFSET
  typedef struct packed {
    logic [2:0] internal_osc_freq_select;
    lpw_osc_mode_t osc_mode;
    logic clock_from_internal;
    logic fail_safe_enable;
    logic global_interrupt_enable;
  } lpw_ctrl_t;

  localparam int CTRL_W = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;

  // Resume command to the core
  typedef struct packed {
    logic resume;
    logic run_next_first;
    logic branch_vector;
    logic restart_zero;
  } lpw_resume_t;

  localparam logic [3:0] RESUME_IDLE = 4'h0;

endpackage

// [rtl/lpw_sync2.sv]
// Two-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
`default_nettype none

module lpw_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta <= INIT[i];
          q[i] <= INIT[i];
        end else if (ce) begin
          meta <= d[i];
          q[i] <= meta;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// [rtl/lpw_watchdog.sv]
// Watchdog counter with postscaler and synchronous clear
`timescale 1ns/1ps
`default_nettype none

module lpw_watchdog #(
  parameter int POSTSCALE = lpw_pkg::WDT_POSTSCALE_DEFAULT,
  parameter int PERIOD = lpw_pkg::WDT_PERIOD_DEFAULT,
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Control
  input wire logic clear,
  // Status
  output logic timeout,
  output logic [CW-1:0] count
);

  logic [CW-1:0] post;
  logic post_wrap;
  logic count_wrap;

  assign post_wrap = (post == CW'(POSTSCALE - 1));
  assign count_wrap = (count == CW'(PERIOD - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      post <= '0;
      count <= '0;
      timeout <= 1'b0;
    end else if (ce) begin
      timeout <= 1'b0;
      if (clear) begin
        post <= '0;
        count <= '0;
      end else if (post_wrap) begin
        post <= '0;
        count <= count_wrap ? '0 : count + 1'b1;
        timeout <= count_wrap;
      end else begin
        post <= post + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// [rtl/lpw_wake_control.sv]
// Sleep and idle exit sequencer with watchdog control and AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: Leave low power only on interrupt, reset, watchdog
// R2: Software enables sources allowed to wake
// R3: Enabled set interrupt flag starts wake
// R4: Interrupt wake runs instruction after sleep first
// R5: Vector branch only with global enable set
// R6: Fixed preparation delay, then resume next cycle
// R7: Watchdog timeout while not executing wakes device
// R8: Watchdog timeout while executing resets device
// R9: Clear watchdog on sleep, clear, clock loss, frequency change
// R10: Reset wake restarts at address zero
// R11: Reset wake delay depends on clocks and oscillator
// R12: Skip start-up timer: primary idle or non-crystal
// R13: Preparation delay applies even without start-up timer
// R14: Stopped crystal waits start-up timer, then preparation
module lpw_wake_control #(
  parameter int IRQ_N = 8,
  parameter int OST_CYCLES = lpw_pkg::OST_CYCLES_DEFAULT,
  parameter int WDT_POSTSCALE = lpw_pkg::WDT_POSTSCALE_DEFAULT,
  parameter int WDT_PERIOD = lpw_pkg::WDT_PERIOD_DEFAULT,
  parameter int CNT_W = 16
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Core
  input wire logic core_sleep_exec,
  input wire lpw_pkg::lpw_pm_mode_t core_sleep_mode,
  input wire logic watchdog_clear_instruction,
  output logic core_halt,
  output lpw_pkg::lpw_resume_t core_resume,
  // Interrupt sources
  input wire logic [IRQ_N-1:0] irq_flags,
  // Pins and monitors from other domains
  input wire logic ext_reset_pin_n,
  input wire logic clock_loss,
  // Reset requests
  output logic wdt_reset,
  output logic ext_reset
);

  lpw_pkg::lpw_state_t state, next_state;
  lpw_pkg::lpw_cause_t cause, next_cause;
  lpw_pkg::lpw_pm_mode_t pm_mode;
  lpw_pkg::lpw_ctrl_t ctrl;
  lpw_pkg::lpw_resume_t next_resume;
  logic [IRQ_N-1:0] peripheral_interrupt_enables;
  logic [CNT_W-1:0] delay_count, next_delay_count;
  logic [CNT_W-1:0] wdt_count;
  logic wdt_timeout;

  // ---------------- Pin synchronisers ----------------
  logic [1:0] pin_sync;
  logic reset_pin_n_s, clock_loss_s;
  logic reset_pin_n_d, clock_loss_d;
  logic reset_evt, clock_loss_evt;

  lpw_sync2 #(
    .W(2),
    .INIT(2'h2)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .d({ext_reset_pin_n, clock_loss}),
    .q(pin_sync)
  );

  assign reset_pin_n_s = pin_sync[1];
  assign clock_loss_s = pin_sync[0];
  assign reset_evt = reset_pin_n_d & ~reset_pin_n_s;
  assign clock_loss_evt = clock_loss_s & ~clock_loss_d;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_pin_n_d <= 1'b1;
      clock_loss_d <= 1'b0;
    end else if (ce) begin
      reset_pin_n_d <= reset_pin_n_s;
      clock_loss_d <= clock_loss_s;
    end
  end

  // ---------------- AXI4-Lite slave ----------------
  logic write_go, read_go;
  logic [7:0] waddr_word, raddr_word;
  logic wr_ctrl, wr_irq_en, wr_ro, wr_hit;
  logic [31:0] wmask, ctrl_word, irq_en_word, status_word;
  logic [31:0] ctrl_merged, irq_en_merged, read_word;
  logic rd_hit;
  lpw_pkg::lpw_ctrl_t next_ctrl;
  logic freq_change;

  assign write_go = ce & awvalid & wvalid & ~bvalid;
  assign read_go = ce & arvalid & ~rvalid;
  assign awready = write_go;
  assign wready = write_go;
  assign arready = ce & ~rvalid;

  assign waddr_word = {awaddr[7:2], 2'b00};
  assign raddr_word = {araddr[7:2], 2'b00};
  assign wr_ctrl = write_go & (waddr_word == lpw_pkg::CTRL_OFFSET);
  assign wr_irq_en = write_go & (waddr_word == lpw_pkg::IRQ_EN_OFFSET);
  assign wr_ro = (waddr_word == lpw_pkg::STATUS_OFFSET) |
                 (waddr_word == lpw_pkg::WDT_COUNT_OFFSET);
  assign wr_hit = wr_ro | (waddr_word == lpw_pkg::CTRL_OFFSET) |
                  (waddr_word == lpw_pkg::IRQ_EN_OFFSET);

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_strb
      assign wmask[8*b +: 8] = {8{wstrb[b]}};
    end
  endgenerate

  assign ctrl_word = 32'(ctrl);
  assign irq_en_word = 32'(peripheral_interrupt_enables);
  assign status_word = 32'({cause, 1'b0, pm_mode, 1'b0, state});
  assign ctrl_merged = (ctrl_word & ~wmask) | (wdata & wmask);
  assign irq_en_merged = (irq_en_word & ~wmask) | (wdata & wmask);
  assign next_ctrl = lpw_pkg::lpw_ctrl_t'(ctrl_merged[lpw_pkg::CTRL_W-1:0]);

  // Only a real change of the select counts while the internal osc runs
  assign freq_change = wr_ctrl & ctrl.clock_from_internal &
    (next_ctrl.internal_osc_freq_select != ctrl.internal_osc_freq_select); // R9

  assign rd_hit = (raddr_word == lpw_pkg::CTRL_OFFSET) |
                  (raddr_word == lpw_pkg::IRQ_EN_OFFSET) |
                  (raddr_word == lpw_pkg::STATUS_OFFSET) |
                  (raddr_word == lpw_pkg::WDT_COUNT_OFFSET);
  assign read_word =
    (raddr_word == lpw_pkg::CTRL_OFFSET) ? ctrl_word :
    (raddr_word == lpw_pkg::IRQ_EN_OFFSET) ? irq_en_word :
    (raddr_word == lpw_pkg::STATUS_OFFSET) ? status_word :
    (raddr_word == lpw_pkg::WDT_COUNT_OFFSET) ? 32'(wdt_count) : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= lpw_pkg::lpw_ctrl_t'(lpw_pkg::CTRL_RESET);
      peripheral_interrupt_enables <= '0;
      bvalid <= 1'b0;
      bresp <= lpw_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl <= next_ctrl;
      end
      if (wr_irq_en) begin
        peripheral_interrupt_enables <= irq_en_merged[IRQ_N-1:0]; // R2
      end
      if (write_go) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? lpw_pkg::RESP_OKAY : lpw_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= lpw_pkg::RESP_OKAY;
    end else if (ce) begin
      if (read_go) begin
        rvalid <= 1'b1;
        rdata <= read_word;
        rresp <= rd_hit ? lpw_pkg::RESP_OKAY : lpw_pkg::RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ---------------- Watchdog ----------------
  logic sleep_taken;
  logic wdt_clear;

  assign sleep_taken = (state == lpw_pkg::ST_RUN) & core_sleep_exec &
                       ~reset_evt & ~wdt_timeout;
  assign wdt_clear = sleep_taken | watchdog_clear_instruction |
                     (clock_loss_evt & ctrl.fail_safe_enable) |
                     freq_change; // R9

  lpw_watchdog #(
    .POSTSCALE(WDT_POSTSCALE),
    .PERIOD(WDT_PERIOD),
    .CW(CNT_W)
  ) u_wdt (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .clear(wdt_clear),
    .timeout(wdt_timeout),
    .count(wdt_count)
  );

  // ---------------- Wake sequencer ----------------
  logic irq_wake;
  logic xtal_primary;
  logic primary_stopped;
  logic need_ost;
  logic ost_done, prep_done;

  assign irq_wake = |(irq_flags & peripheral_interrupt_enables); // R3
  assign xtal_primary =
    (ctrl.osc_mode == lpw_pkg::OSC_LOW_POWER_XTAL) |
    (ctrl.osc_mode == lpw_pkg::OSC_STANDARD_XTAL) |
    (ctrl.osc_mode == lpw_pkg::OSC_HIGH_SPEED_XTAL) |
    (ctrl.osc_mode == lpw_pkg::OSC_HIGH_SPEED_XTAL_WITH_PLL);
  // Primary idle keeps the oscillator running, so no start-up wait
  assign primary_stopped = (state == lpw_pkg::ST_ASLEEP) &
                           (pm_mode != lpw_pkg::PM_PRIMARY_CLOCK_IDLE);
  assign need_ost = xtal_primary & primary_stopped; // R12 R14
  assign ost_done = (delay_count == CNT_W'(OST_CYCLES - 1));
  assign prep_done = (delay_count == CNT_W'(lpw_pkg::CORE_PREP_CYCLES - 1));

  always_comb begin
    next_state = state;
    next_cause = cause;
    next_delay_count = '0;
    case (state)
      lpw_pkg::ST_RUN: begin
        if (reset_evt) begin
          next_state = lpw_pkg::ST_CORE_PREP;
          next_cause = lpw_pkg::CAUSE_RESET;
        end else if (wdt_timeout) begin
          next_state = lpw_pkg::ST_CORE_PREP; // R8
          next_cause = lpw_pkg::CAUSE_WDT_RESET;
        end else if (core_sleep_exec) begin
          next_state = lpw_pkg::ST_ASLEEP;
          next_cause = lpw_pkg::CAUSE_NONE;
        end
      end
      lpw_pkg::ST_ASLEEP: begin
        // Only these three events end the low power mode
        if (reset_evt | wdt_timeout | irq_wake) begin // R1
          next_state = need_ost ? lpw_pkg::ST_OSC_START
                                : lpw_pkg::ST_CORE_PREP; // R11 R13
          if (reset_evt) begin
            next_cause = lpw_pkg::CAUSE_RESET;
          end else if (wdt_timeout) begin
            next_cause = lpw_pkg::CAUSE_WDT_WAKE; // R7
          end else begin
            next_cause = lpw_pkg::CAUSE_IRQ;
          end
        end
      end
      lpw_pkg::ST_OSC_START: begin
        if (reset_evt) begin
          next_cause = lpw_pkg::CAUSE_RESET;
        end
        if (ost_done) begin
          next_state = lpw_pkg::ST_CORE_PREP; // R14
        end else begin
          next_delay_count = delay_count + 1'b1;
        end
      end
      lpw_pkg::ST_CORE_PREP: begin
        if (reset_evt) begin
          next_cause = lpw_pkg::CAUSE_RESET;
        end
        if (prep_done) begin
          next_state = lpw_pkg::ST_RESUME; // R6
        end else begin
          next_delay_count = delay_count + 1'b1;
        end
      end
      lpw_pkg::ST_RESUME: begin
        next_state = lpw_pkg::ST_RUN;
      end
      default: begin
        next_state = lpw_pkg::ST_RUN;
      end
    endcase
  end

  // Resume command, issued in the cycle right after the preparation delay
  logic entering_resume;
  logic irq_cause, restart_cause;

  assign entering_resume = (state == lpw_pkg::ST_CORE_PREP) & prep_done; // R6
  assign irq_cause = (next_cause == lpw_pkg::CAUSE_IRQ);
  assign restart_cause = (next_cause == lpw_pkg::CAUSE_RESET) |
                         (next_cause == lpw_pkg::CAUSE_WDT_RESET);

  always_comb begin
    next_resume = lpw_pkg::lpw_resume_t'(lpw_pkg::RESUME_IDLE);
    next_resume.resume = entering_resume;
    next_resume.run_next_first = entering_resume & irq_cause; // R4
    next_resume.branch_vector = entering_resume & irq_cause &
                                ctrl.global_interrupt_enable; // R5
    next_resume.restart_zero = entering_resume & restart_cause; // R10
  end

  // Power-up behaves as a reset wake: preparation delay, then address zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= lpw_pkg::ST_CORE_PREP;
      cause <= lpw_pkg::CAUSE_RESET;
      pm_mode <= lpw_pkg::PM_SLEEP;
      delay_count <= '0;
      core_halt <= 1'b1;
      core_resume <= lpw_pkg::lpw_resume_t'(lpw_pkg::RESUME_IDLE);
      wdt_reset <= 1'b0;
      ext_reset <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      cause <= next_cause;
      delay_count <= next_delay_count;
      if (sleep_taken) begin
        pm_mode <= core_sleep_mode;
      end
      core_halt <= (next_state != lpw_pkg::ST_RUN);
      core_resume <= next_resume;
      wdt_reset <= (state == lpw_pkg::ST_RUN) & wdt_timeout &
                   ~reset_evt; // R8
      ext_reset <= reset_evt;
    end
  end

endmodule

`default_nettype wire

// [verification/lpw_wake_control_checker.sv]
// Port assertions for the wake sequencer
`timescale 1ns/1ps
`default_nettype none

module lpw_wake_control_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  // Core side
  input wire logic core_halt,
  input wire lpw_pkg::lpw_resume_t core_resume,
  input wire logic wdt_reset
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Consecutive halted edges, saturating
  logic [3:0] halt_run;
  always_ff @(posedge aclk) begin
    if (!aresetn || !core_halt) begin
      halt_run <= 4'h0;
    end else if (halt_run != 4'hf) begin
      halt_run <= halt_run + 4'h1;
    end
  end

  sequence s_resume_then_run;
    core_resume.resume ##1 (!core_resume.resume && !core_halt);
  endsequence

  AST_RESUME_RUN: assert property (core_resume.resume |-> s_resume_then_run)
    else $error("resume not followed by run");
  AST_HALT_FALL: assert property ($fell(core_halt) |-> $past(core_resume.resume))
    else $error("halt dropped without resume");
  // Prep lasts four cycles; halt rises with state, so the bound leaves one cycle of slack
  AST_PREP_HELD: assert property (core_resume.resume |-> halt_run >= 4'h3)
    else $error("resume before prep delay");
  AST_VECTOR_NEXT: assert property (core_resume.branch_vector |-> core_resume.run_next_first && core_resume.resume)
    else $error("vector without next instruction");
  AST_IRQ_NO_ZERO: assert property (core_resume.run_next_first |-> !core_resume.restart_zero)
    else $error("interrupt wake restarted at zero");
  AST_WDT_RUN: assert property (wdt_reset |-> !$past(core_halt))
    else $error("watchdog reset while halted");
  AST_WDT_ZERO: assert property (wdt_reset |-> ##[2:6] (core_resume.resume && core_resume.restart_zero))
    else $error("watchdog reset without restart");
  AST_WR_ANSWER: assert property (awvalid && awready |=> bvalid)
    else $error("write not answered");
  AST_RD_ANSWER: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
endmodule

bind lpw_wake_control lpw_wake_control_checker lpw_wake_control_checker_i (
  .aclk, .aresetn, .awvalid, .awready, .bvalid, .arvalid, .arready, .rvalid,
  .core_halt, .core_resume, .wdt_reset
);

`default_nettype wire

// [verification/lpw_core_model.sv]
// Behavioural core: sleeps on request, services the watchdog while running
`timescale 1ns/1ps
`default_nettype none

module lpw_core_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench requests
  input wire logic sleep_req,
  input wire lpw_pkg::lpw_pm_mode_t sleep_mode_req,
  input wire logic kick_en,
  // Block side
  input wire logic core_halt,
  output logic core_sleep_exec,
  output lpw_pkg::lpw_pm_mode_t core_sleep_mode,
  output logic watchdog_clear_instruction
);
  logic [3:0] kick_cnt;
  // A halted core executes nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_sleep_exec <= 1'b0;
      core_sleep_mode <= lpw_pkg::PM_SLEEP;
      watchdog_clear_instruction <= 1'b0;
      kick_cnt <= 4'h0;
    end else begin
      core_sleep_exec <= sleep_req && !core_halt;
      core_sleep_mode <= sleep_mode_req;
      watchdog_clear_instruction <= kick_en && !core_halt && kick_cnt == 4'h0;
      kick_cnt <= kick_cnt + 4'h1;
    end
  end
endmodule

`default_nettype wire

// [verification/lpw_wake_control_tb.sv]
// Self-checking bench for the wake sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  num_errors++; $display("Error %s expected %h seen %h", nm, e, g); end end

module lpw_wake_control_tb;
  localparam int OSCILLATOR_STARTUP_TIMER = 8;
  localparam int PREP = lpw_pkg::CORE_PREP_CYCLES;
  localparam logic [7:0] CT = lpw_pkg::CTRL_OFFSET;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready;
  logic wready, bvalid, arready, rvalid, wdt_reset, ext_reset, sleep_req;
  logic kick_en, pin_n, closs, sexec, wdc, core_halt;
  logic [7:0] awaddr, araddr, irq_flags;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  lpw_pkg::lpw_pm_mode_t smode, cmode;
  lpw_pkg::lpw_resume_t core_resume;
  int num_errors, tests_run, wdt_hits, ext_hits, n;

  lpw_wake_control #(.OST_CYCLES(OSCILLATOR_STARTUP_TIMER), .WDT_POSTSCALE(4), .WDT_PERIOD(16))
  lpw_wake_control_i (.aclk, .aresetn, .ce(1'b1), .awaddr, .awvalid,
    .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .core_sleep_exec(sexec), .core_sleep_mode(cmode),
    .watchdog_clear_instruction(wdc), .core_halt, .core_resume, .irq_flags,
    .ext_reset_pin_n(pin_n), .clock_loss(closs), .wdt_reset, .ext_reset);
  lpw_core_model lpw_core_model_i (.aclk, .aresetn, .sleep_req,
    .sleep_mode_req(smode), .kick_en, .core_halt, .core_sleep_exec(sexec),
    .core_sleep_mode(cmode), .watchdog_clear_instruction(wdc));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (wdt_reset === 1'b1) wdt_hits++;
    if (ext_reset === 1'b1) ext_hits++;
  end

  function automatic int wake_delay(input int osc, input int pm);
    // Crystal modes restart the oscillator unless primary idle kept it
    // Counted from the edge taking the trigger; pulse seen one edge late
    if (osc < 4 && pm != 1) return OSCILLATOR_STARTUP_TIMER + PREP + 2;
    return PREP + 2;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er = lpw_pkg::RESP_OKAY);
    int k;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    k = 0;
    do @(posedge aclk); while (!awready && k++ < 50);
    {awvalid, wvalid} <= 2'h0;
    do @(posedge aclk); while (!bvalid && k++ < 50);
    bready <= 1'b0;
    `CHK("bvalid", 1'b1, bvalid)
    `CHK("bresp", er, bresp)
    // An idle edge, so a following call never reassigns bready here
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er = lpw_pkg::RESP_OKAY);
    int k;
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    k = 0;
    do @(posedge aclk); while (!arready && k++ < 50);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid && k++ < 50);
    rready <= 1'b0;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
    `CHK("rresp", er, rresp)
    // An idle edge, so a following call never reassigns rready here
    @(posedge aclk);
  endtask

  // Counts edges until the resume pulse is seen
  task automatic wres();
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (core_resume.resume !== 1'b1 && n < 3000);
  endtask

  task automatic nap(input lpw_pkg::lpw_pm_mode_t m);
    int k;
    smode <= m;
    sleep_req <= 1'b1;
    @(posedge aclk);
    sleep_req <= 1'b0;
    k = 0;
    do @(posedge aclk); while (core_halt !== 1'b1 && k++ < 20);
  endtask

  task automatic stop_test();
    if (num_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #(50 * 20000);
    num_errors++;
    stop_test();
  end

  initial begin
    logic [2:0] b;
    logic gie;
    int k;
    void'($urandom(43));
    {aresetn, awvalid, wvalid, bready, arvalid, rready, sleep_req} = '0;
    {awaddr, araddr, wdata, irq_flags, closs} = '0;
    {kick_en, pin_n} = 2'h3;
    smode = lpw_pkg::PM_SLEEP;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    wres();
    `CHK("rst_delay", PREP + 1, n)
    `CHK("rst_zero", 1'b1, core_resume.restart_zero)
    rd(CT, 32'h0);
    rd(lpw_pkg::IRQ_EN_OFFSET, 32'h0);
    wr(8'h10, 32'h1, lpw_pkg::RESP_SLVERR);
    rd(8'h10, 32'h0, lpw_pkg::RESP_SLVERR);
    wr(CT, 32'hffff_fe00);
    rd(CT, 32'h0);
    // Every oscillator mode against every low power mode
    for (int i = 0; i < 32; i++) begin
      b = 3'($urandom);
      gie = 1'($urandom);
      wr(lpw_pkg::IRQ_EN_OFFSET, 32'h1 << b);
      wr(CT, {26'h0, 3'(i), 2'h0, gie});
      nap(lpw_pkg::lpw_pm_mode_t'(i / 8));
      irq_flags <= 8'($urandom) & ~(8'h1 << b);
      repeat (10) @(posedge aclk);
      `CHK("asleep", 1'b1, core_halt)
      irq_flags <= 8'h1 << b;
      wres();
      `CHK("delay", wake_delay(i % 8, i / 8), n)
      `CHK("next", 1'b1, core_resume.run_next_first)
      `CHK("vector", gie, core_resume.branch_vector)
      irq_flags <= 8'h0;
      repeat (3) @(posedge aclk);
    end
    nap(lpw_pkg::PM_SECONDARY_IDLE);
    wres();
    `CHK("wdt_fields", 3'h0, core_resume[2:0])
    `CHK("wdt_time", 1'b1, n > 50 && n < 80)
    `CHK("wdt_no_rst", 0, wdt_hits)
    // Watchdog starved: only the monitored clears keep it quiet
    kick_en <= 1'b0;
    wr(CT, 32'h2);
    repeat (6) begin
      closs <= 1'b1;
      repeat (20) @(posedge aclk);
      closs <= 1'b0;
      repeat (20) @(posedge aclk);
    end
    `CHK("loss_clear", 0, wdt_hits)
    wr(CT, 32'h4);
    for (int j = 1; j < 7; j++) begin
      wr(CT, {23'h0, 3'(j), 6'h4});
      repeat (36) @(posedge aclk);
    end
    `CHK("freq_clear", 0, wdt_hits)
    wr(CT, 32'h0);
    k = 0;
    while (wdt_reset !== 1'b1 && k++ < 200) @(posedge aclk);
    `CHK("wdt_reset", 1'b1, wdt_reset)
    wres();
    `CHK("wdt_zero", 1'b1, core_resume.restart_zero)
    kick_en <= 1'b1;
    repeat (8) @(posedge aclk);
    nap(lpw_pkg::PM_RC_IDLE);
    pin_n <= 1'b0;
    wres();
    pin_n <= 1'b1;
    // Two synchroniser edges pass before the pin event is taken
    `CHK("pin_delay", wake_delay(0, 3) + 2, n)
    `CHK("pin_zero", 1'b1, core_resume.restart_zero)
    `CHK("pin_seen", 1, ext_hits)
    stop_test();
  end
endmodule

`default_nettype wire
